// *** rtl/conversion_status_limit_flags.sv ***
// configuration status bits, limit flags and result exponent masking
// assumes the serial interface gives one-cycle read/write strobes on ref_clk
// and that conversion results, limits and overflow come from same-clock logic
`timescale 1ns/1ns
`default_nettype none
module conversion_status_limit_flags (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // configuration register access
    input wire logic cfgWrite,
    input wire logic cfgRead,
    input wire logic [light_flags_pkg::DATA_W-1:0] cfgWriteData,
    output logic [light_flags_pkg::DATA_W-1:0] cfgReadData,
    // conversion side
    input wire logic convDone,
    input wire logic [light_flags_pkg::DATA_W-1:0] convResult,
    input wire logic convOverflow,
    input wire logic [light_flags_pkg::DATA_W-1:0] lowLimit,
    input wire logic [light_flags_pkg::DATA_W-1:0] highLimit,
    // status out
    output logic [light_flags_pkg::DATA_W-1:0] resultReadData,
    output logic [1:0] operatingMode,
    output logic conversion_done_flag,
    output logic above_threshold_event,
    output logic below_threshold_event
);
    import light_flags_pkg::*;

    typedef struct packed {
        logic [3:0] range_choice;
        logic contTime;
        logic [1:0] mode;
        logic overflow;
        logic doneFlag;
        logic aboveFlag;
        logic belowFlag;
        logic polarity;
        logic exponent_mask_enable;
        logic [1:0] consecutive_fault_setting;
        logic [CNT_W-1:0] aboveCnt;
        logic [CNT_W-1:0] belowCnt;
        logic [DATA_W-1:0] readData;
        logic [DATA_W-1:0] result;
    } state_t;

    state_t state_reg;
    state_t state_next;

    // lux compare: mantissa shifted by exponent, so differing exponents compare right
    function automatic logic [LUX_W-1:0] toLux(input logic [DATA_W-1:0] v);
        logic [LUX_W-1:0] m;
        m = {{(LUX_W-12){1'b0}}, v[11:0]};
        return m << v[15:12];
    endfunction

    logic [LUX_W-1:0] resLux;
    logic [LUX_W-1:0] hiLux;
    logic [LUX_W-1:0] loLux;
    logic [CNT_W-1:0] need;
    logic isAbove;
    logic isBelow;
    logic [CNT_W-1:0] aboveInc;
    logic [CNT_W-1:0] belowInc;

    always_comb begin
        resLux = toLux(convResult);
        hiLux = toLux(highLimit);
        loLux = toLux(lowLimit);
        // raw result used here, masking never reaches the compare
        isAbove = resLux > hiLux;
        isBelow = resLux < loLux;
        // 00 one, 01 two, 10 four, 11 eight
        need = CNT_W'(1) << state_reg.consecutive_fault_setting;
        // counts saturate at eight so a long fault run cannot wrap
        aboveInc = (state_reg.aboveCnt >= 4'h8) ? 4'h8 : state_reg.aboveCnt + 4'h1;
        belowInc = (state_reg.belowCnt >= 4'h8) ? 4'h8 : state_reg.belowCnt + 4'h1;

        state_next = state_reg;
        // read captures pre-clear values
        if (cfgRead) begin
            state_next.readData = {state_reg.range_choice, state_reg.contTime,
                state_reg.mode, state_reg.overflow, state_reg.doneFlag,
                state_reg.aboveFlag, state_reg.belowFlag, LATCH_READ,
                state_reg.polarity, state_reg.exponent_mask_enable,
                state_reg.consecutive_fault_setting};
            state_next.doneFlag = 1'b0;
            // threshold flags also clear on read, as a latched status
            state_next.aboveFlag = 1'b0;
            state_next.belowFlag = 1'b0;
        end
        // flag bits in the write data are ignored
        if (cfgWrite) begin
            state_next.range_choice = cfgWriteData[RANGE_LSB +: 4];
            state_next.contTime = cfgWriteData[CONTTIME_BIT];
            state_next.mode = cfgWriteData[MODE_LSB +: 2];
            state_next.polarity = cfgWriteData[POLARITY_BIT];
            state_next.exponent_mask_enable = cfgWriteData[MASK_BIT];
            state_next.consecutive_fault_setting = cfgWriteData[FAULT_LSB +: 2];
            // shutdown write leaves the done flag alone
            if (cfgWriteData[MODE_LSB +: 2] != MODE_SHUTDOWN)
                state_next.doneFlag = 1'b0;
        end
        if (convDone) begin
            state_next.doneFlag = 1'b1; // set wins over a same-cycle clear
            state_next.overflow = convOverflow;
            // exponent forced to zero only in the result view
            if (state_reg.exponent_mask_enable && state_reg.range_choice < RANGE_AUTO)
                state_next.result = {4'h0, convResult[11:0]};
            else
                state_next.result = convResult;
            // a fresh write of the mode takes priority over the auto return
            if (state_reg.mode == MODE_SINGLE && !cfgWrite)
                state_next.mode = MODE_SHUTDOWN;
            if (isAbove) begin
                state_next.aboveCnt = aboveInc;
                if (aboveInc >= need)
                    state_next.aboveFlag = 1'b1;
            end else begin
                state_next.aboveCnt = '0;
            end
            if (isBelow) begin
                state_next.belowCnt = belowInc;
                if (belowInc >= need)
                    state_next.belowFlag = 1'b1;
            end else begin
                state_next.belowCnt = '0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg.range_choice <= RANGE_RESET;
            state_reg.contTime <= CONTTIME_RESET;
            state_reg.mode <= MODE_RESET;
            state_reg.overflow <= 1'b0;
            state_reg.doneFlag <= 1'b0;
            state_reg.aboveFlag <= 1'b0;
            state_reg.belowFlag <= 1'b0;
            state_reg.polarity <= POLARITY_RESET;
            state_reg.exponent_mask_enable <= MASK_RESET;
            state_reg.consecutive_fault_setting <= FAULT_RESET;
            state_reg.aboveCnt <= '0;
            state_reg.belowCnt <= '0;
            state_reg.readData <= '0;
            state_reg.result <= RESULT_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign cfgReadData = state_reg.readData;
    assign resultReadData = state_reg.result;
    assign operatingMode = state_reg.mode;
    assign conversion_done_flag = state_reg.doneFlag;
    assign above_threshold_event = state_reg.aboveFlag;
    assign below_threshold_event = state_reg.belowFlag;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    property p_done_set;
        convDone |=> conversion_done_flag;
    endproperty
    a_done_set: assert property (p_done_set) else $error("done flag not set");

    property p_done_read_clear;
        cfgRead && !convDone |=> !conversion_done_flag;
    endproperty
    a_done_read_clear: assert property (p_done_read_clear) else $error("read left done flag");

    property p_done_shutdown_keep;
        cfgWrite && !cfgRead && !convDone && cfgWriteData[MODE_LSB +: 2] == MODE_SHUTDOWN
            |=> $stable(conversion_done_flag);
    endproperty
    a_done_shutdown_keep: assert property (p_done_shutdown_keep) else $error("shutdown write hit flag");

    property p_above_needs_count;
        $rose(above_threshold_event) |-> $past(state_reg.aboveCnt) + 4'h1 >= $past(need);
    endproperty
    a_above_needs_count: assert property (p_above_needs_count) else $error("above flag too early");

    property p_below_one;
        convDone && isBelow && state_reg.consecutive_fault_setting == 2'h0 |=> below_threshold_event;
    endproperty
    a_below_one: assert property (p_below_one) else $error("below flag missing");

    property p_mask;
        convDone && state_reg.exponent_mask_enable && state_reg.range_choice < RANGE_AUTO
            |=> resultReadData[15:12] == 4'h0 && resultReadData[11:0] == $past(convResult[11:0]);
    endproperty
    a_mask: assert property (p_mask) else $error("exponent not masked");

    property p_nomask;
        convDone && !state_reg.exponent_mask_enable |=> resultReadData == $past(convResult);
    endproperty
    a_nomask: assert property (p_nomask) else $error("result altered");

    property p_single_done;
        convDone && operatingMode == MODE_SINGLE && !cfgWrite |=> operatingMode == MODE_SHUTDOWN;
    endproperty
    a_single_done: assert property (p_single_done) else $error("single shot stuck");

    property p_restart;
        convDone && !isAbove |=> state_reg.aboveCnt == 4'h0;
    endproperty
    a_restart: assert property (p_restart) else $error("count not restarted");

    property p_write_fields;
        cfgWrite |=> state_reg.consecutive_fault_setting == $past(cfgWriteData[1:0])
            && state_reg.exponent_mask_enable == $past(cfgWriteData[MASK_BIT]);
    endproperty
    a_write_fields: assert property (p_write_fields) else $error("field write lost");

    property p_below_needs_count;
        $rose(below_threshold_event) |-> $past(state_reg.belowCnt) + 4'h1 >= $past(need);
    endproperty
    a_below_needs_count: assert property (p_below_needs_count) else $error("below too early");

    property p_above_one;
        convDone && isAbove && state_reg.consecutive_fault_setting == 2'h0 |=> above_threshold_event;
    endproperty
    a_above_one: assert property (p_above_one) else $error("above flag missing");

    property p_below_restart;
        convDone && !isBelow |=> state_reg.belowCnt == 4'h0;
    endproperty
    a_below_restart: assert property (p_below_restart) else $error("below count kept");

    property p_done_write_clear;
        cfgWrite && !convDone && cfgWriteData[MODE_LSB +: 2] != MODE_SHUTDOWN
            |=> !conversion_done_flag;
    endproperty
    a_done_write_clear: assert property (p_done_write_clear) else $error("write left done");

    property p_done_needs_conv;
        $rose(conversion_done_flag) |-> $past(convDone);
    endproperty
    a_done_needs_conv: assert property (p_done_needs_conv) else $error("done set idle");

    property p_above_needs_conv;
        $rose(above_threshold_event) |-> $past(convDone) && $past(isAbove);
    endproperty
    a_above_needs_conv: assert property (p_above_needs_conv) else $error("above set idle");

    property p_below_needs_conv;
        $rose(below_threshold_event) |-> $past(convDone) && $past(isBelow);
    endproperty
    a_below_needs_conv: assert property (p_below_needs_conv) else $error("below set idle");

    // host writes cannot touch the above and below threshold flags
    property p_flags_hold;
        !convDone && !cfgRead |=> $stable(above_threshold_event) && $stable(below_threshold_event);
    endproperty
    a_flags_hold: assert property (p_flags_hold) else $error("flag moved by write");

    property p_fields_hold;
        !cfgWrite |=> $stable(state_reg.consecutive_fault_setting)
            && $stable(state_reg.exponent_mask_enable);
    endproperty
    a_fields_hold: assert property (p_fields_hold) else $error("field moved");

    property p_mode_hold;
        !cfgWrite && !convDone |=> $stable(operatingMode);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode moved");

    property p_result_hold;
        !convDone |=> $stable(resultReadData);
    endproperty
    a_result_hold: assert property (p_result_hold) else $error("result moved");

    property p_read_done_bit;
        cfgRead |=> cfgReadData[DONE_BIT] == $past(conversion_done_flag);
    endproperty
    a_read_done_bit: assert property (p_read_done_bit) else $error("done bit misread");

    property p_mask_auto;
        convDone && state_reg.range_choice >= RANGE_AUTO |=> resultReadData == $past(convResult);
    endproperty
    a_mask_auto: assert property (p_mask_auto) else $error("auto range masked");

    // saturation keeps the count from wrapping back under the need
    property p_count_sat;
        state_reg.aboveCnt <= 4'h8 && state_reg.belowCnt <= 4'h8;
    endproperty
    a_count_sat: assert property (p_count_sat) else $error("fault count past eight");

    property p_overflow;
        convDone |=> state_reg.overflow == $past(convOverflow);
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow not taken");

    c_above_eight: cover property (state_reg.consecutive_fault_setting == 2'h3 ##1
        $rose(above_threshold_event));
    c_single_shot: cover property (operatingMode == MODE_SINGLE ##1 operatingMode == MODE_SHUTDOWN);
    c_read_and_done: cover property (cfgRead && convDone);
    c_mask_active: cover property (convDone && state_reg.exponent_mask_enable
        && state_reg.range_choice < RANGE_AUTO);
    c_below_flag: cover property ($rose(below_threshold_event));
endmodule
`default_nettype wire

// *** rtl/light_flags_pkg.sv ***
// constants for the conversion status and limit flag logic
// assumes one internal clock; limits and results arrive from neighbouring logic
//
// What this block does
// - the conversion-done flag is set to one each time a light conversion ends.
// - that flag clears on a later configuration read, or a later write whose mode is not shutdown.
// - a configuration write that selects shutdown leaves the conversion-done flag as it was.
// - the above-threshold flag sets when the result exceeds the high limit for N measurements.
// - the below-threshold flag sets when the result is under the low limit for N measurements.
// - the two-bit fault setting picks N as one, two, four or eight, and resets to one.
// - with masking on and a manual range below automatic, the result exponent reads as zero.
// - masking touches only the result read value, never the limit comparisons.
// - the mask enable and fault setting are read/write and reset to zero.
// - conversion-done and both threshold flags are read-only and reset to zero.
// - in single-shot the mode reads one while converting and drops to shutdown when done.
package light_flags_pkg;
    // configuration field positions
    localparam int RANGE_LSB = 12;
    localparam int CONTTIME_BIT = 11;
    localparam int MODE_LSB = 9;
    localparam int OVERFLOW_BIT = 8;
    localparam int DONE_BIT = 7;
    localparam int ABOVE_BIT = 6;
    localparam int BELOW_BIT = 5;
    localparam int LATCH_BIT = 4;
    localparam int POLARITY_BIT = 3;
    localparam int MASK_BIT = 2;
    localparam int FAULT_LSB = 0;
    // mode and range encodings
    localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
    localparam logic [1:0] MODE_SINGLE = 2'h1;
    localparam logic [3:0] RANGE_AUTO = 4'hC;
    // reset values
    localparam logic [3:0] RANGE_RESET = 4'hC;
    localparam logic CONTTIME_RESET = 1'b1;
    localparam logic [1:0] MODE_RESET = 2'h0;
    localparam logic POLARITY_RESET = 1'b0;
    localparam logic MASK_RESET = 1'b0;
    localparam logic [1:0] FAULT_RESET = 2'h0;
    localparam logic LATCH_READ = 1'b1;
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    // widths
    localparam int DATA_W = 16;
    localparam int LUX_W = 28;
    localparam int CNT_W = 4;
endpackage

// *** sim/cfg_host_model.sv ***
// host side of the configuration register, one strobe per access
// assumes callers enter its tasks just after a rising edge
`timescale 1ns/1ns
`default_nettype none
module cfg_host_model (
    // clock
    input wire logic ref_clk,
    // strobes to the block
    output logic cfgWrite,
    output logic cfgRead,
    output logic [15:0] cfgWriteData
);
    initial begin
        cfgWrite = 1'b0;
        cfgRead = 1'b0;
        cfgWriteData = 16'hffff;
    end
    task automatic hostWrite(input logic [15:0] d);
        cfgWrite <= 1'b1;
        cfgWriteData <= d;
        @(posedge ref_clk);
        cfgWrite <= 1'b0;
        // idle data is not the last word, so a stale sample shows
        cfgWriteData <= ~d;
    endtask
    task automatic hostRead();
        cfgRead <= 1'b1;
        @(posedge ref_clk);
        cfgRead <= 1'b0;
    endtask
endmodule
`default_nettype wire

// *** sim/conversion_status_limit_flags_bench.sv ***
// self-checking bench for the status and limit flag block
// assumes limits and results are driven here in place of the converter
`timescale 1ns/1ns
`default_nettype none
module conversion_status_limit_flags_bench;
    import light_flags_pkg::*;
    logic ref_clk, rstn, convDone, convOverflow;
    logic [15:0] convResult, lowLimit, highLimit;
    wire logic cfgWrite, cfgRead, doneF, aboveF, belowF;
    wire logic [15:0] cfgWriteData, cfgReadData, resultReadData;
    wire logic [1:0] operatingMode;
    int error_cnt = 0, compares = 0, aCnt = 0, bCnt = 0;
    int mRange = 12, mMode = 0, mOvf = 0, mDone = 0, mAbove = 0, mBelow = 0, mMask = 0, mFc = 0;
    int nTab[$] = '{1, 2, 4, 8};
    logic [15:0] mRes = 16'h0000;
    logic [15:0] e;
    cfg_host_model u_host (.ref_clk(ref_clk), .cfgWrite(cfgWrite), .cfgRead(cfgRead),
        .cfgWriteData(cfgWriteData));
    conversion_status_limit_flags u_dut (.ref_clk(ref_clk), .rstn(rstn),
        .cfgWrite(cfgWrite), .cfgRead(cfgRead), .cfgWriteData(cfgWriteData),
        .cfgReadData(cfgReadData), .convDone(convDone), .convResult(convResult),
        .convOverflow(convOverflow), .lowLimit(lowLimit), .highLimit(highLimit),
        .resultReadData(resultReadData), .operatingMode(operatingMode),
        .conversion_done_flag(doneF), .above_threshold_event(aboveF),
        .below_threshold_event(belowF));
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    function automatic logic [15:0] cfgVal(int rng, int md, int mk, int fc);
        return {4'(rng), 1'b1, 2'(md), 5'h00, 1'b0, 1'(mk), 2'(fc)};
    endfunction
    function automatic longint lux(logic [15:0] v);
        return longint'(v[11:0]) << v[15:12];
    endfunction
    task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] g);
        compares++;
        if (g !== ex) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, ex, g);
        end
    endtask
    task automatic chkAll();
        chk("done", 16'(mDone), 16'(doneF));
        chk("above", 16'(mAbove), 16'(aboveF));
        chk("below", 16'(mBelow), 16'(belowF));
        chk("mode", 16'(mMode), 16'(operatingMode));
        chk("result", mRes, resultReadData);
        @(posedge ref_clk);
    endtask
    task automatic conv(input logic [15:0] r, input logic ov);
        convDone <= 1'b1;
        convResult <= r;
        convOverflow <= ov;
        @(posedge ref_clk);
        convDone <= 1'b0;
        convResult <= ~r;
        aCnt = lux(r) > lux(highLimit) ? (aCnt < 8 ? aCnt + 1 : 8) : 0;
        bCnt = lux(r) < lux(lowLimit) ? (bCnt < 8 ? bCnt + 1 : 8) : 0;
        if (aCnt >= nTab[mFc]) mAbove = 1;
        if (bCnt >= nTab[mFc]) mBelow = 1;
        mRes = (mMask == 1 && mRange < 12) ? {4'h0, r[11:0]} : r;
        mOvf = ov;
        mDone = 1;
        if (mMode == 1) mMode = 0;
        #1 chkAll();
    endtask
    task automatic wr(input logic [15:0] d);
        u_host.hostWrite(d);
        mRange = d[15:12];
        mMode = d[10:9];
        mMask = d[2];
        mFc = d[1:0];
        if (d[10:9] != 2'h0) mDone = 0;
        #1 chkAll();
    endtask
    task automatic rd();
        e = {4'(mRange), 1'b1, 2'(mMode), 1'(mOvf), 1'(mDone), 1'(mAbove), 1'(mBelow),
            1'b1, 1'b0, 1'(mMask), 2'(mFc)};
        u_host.hostRead();
        mDone = 0;
        mAbove = 0;
        mBelow = 0;
        #1 chk("config", e, cfgReadData);
        chkAll();
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #5_000_000;
        error_cnt++;
        summarize();
    end
    initial begin
        rstn = 1'b0;
        convDone = 1'b0;
        convOverflow = 1'b0;
        convResult = 16'h0000;
        lowLimit = 16'h1100;
        highLimit = 16'h2800;
        void'($urandom(32'h28d6_0f1e));
        repeat (4) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        rd();
        $display("test reset values done");
        conv(16'h1200, 1'b1);
        rd();
        conv(16'h1200, 1'b0);
        wr(cfgVal(12, 0, 0, 0));
        wr(cfgVal(12, 2, 0, 0));
        $display("test done flag done");
        for (int fc = 0; fc < 4; fc++) begin
            wr(cfgVal(12, 2, 0, fc));
            repeat (nTab[fc] - 1) conv(16'h3800, 1'b0);
            conv(16'h1200, 1'b0);
            repeat (nTab[fc]) conv(16'h3800, 1'b0);
            repeat (nTab[fc]) conv(16'h0010, 1'b0);
            rd();
        end
        $display("test fault counts done");
        wr(cfgVal(5, 2, 1, 0));
        conv(16'h3800, 1'b0);
        wr(cfgVal(12, 2, 1, 0));
        conv(16'h3800, 1'b0);
        $display("test masking done");
        wr(cfgVal(12, 1, 0, 0));
        conv(16'h1200, 1'b0);
        $display("test single shot done");
        repeat (300) begin
            case ($urandom_range(0, 2))
                0: begin
                    lowLimit <= {4'($urandom_range(0, 11)), 12'($urandom)};
                    highLimit <= {4'($urandom_range(0, 11)), 12'($urandom)};
                    @(posedge ref_clk);
                    conv({4'($urandom_range(0, 11)), 12'($urandom)}, 1'($urandom));
                end
                1: wr(cfgVal($urandom_range(0, 12), $urandom_range(0, 3), $urandom_range(0, 1),
                    $urandom_range(0, 3)) | (16'($urandom) & 16'h01f0));
                default: rd();
            endcase
        end
        $display("test random traffic done");
        summarize();
    end
endmodule
`default_nettype wire
